// file: hdl/clock_guard_reset_sequencer.sv
/*
  Clock safeguard and reset sequencer: tick filtering, backup oscillator
  failover, reset source merge, delay and reset vector fetch, with an
  AHB-Lite register slave. Assumes oscillator edges, pin levels and option
  straps arrive synchronous to hclk; the core consumes int_clk_en.
*/
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
module clock_guard_reset_sequencer (
  input wire logic hclk,               // Bus clock, 250 MHz
  input wire logic hresetn,            // Async reset, low
  input wire logic hsel,               // AHB select
  input wire logic [31:0] haddr,       // AHB address
  input wire logic [1:0] htrans,       // AHB transfer type
  input wire logic hwrite,             // AHB write
  input wire logic [2:0] hsize,        // AHB size
  input wire logic [31:0] hwdata,      // AHB write data
  input wire logic hready,             // AHB bus ready
  output logic hreadyout,              // AHB slave ready
  output logic hresp,                  // AHB response
  output logic [31:0] hrdata,          // AHB read data
  input wire logic safeguard_enable_option, // Option strap
  input wire logic lvd_enable_option,  // Option strap
  input wire logic [1:0] supply_level, // Supply level code
  input wire logic main_osc_edge,      // Main oscillator edge pulse
  input wire logic backup_osc_edge,    // Backup oscillator edge pulse
  input wire logic low_supply,         // Detector below threshold
  input wire logic wdg_end_of_count,   // Watchdog reset pulse
  input wire logic stop_mode,          // Core in stop
  input wire logic reset_pin_in,       // Reset pin level
  output logic reset_pin_out,          // Reset pin drive value
  output logic reset_pin_oe_n,         // Reset pin enable, low drives
  output logic main_osc_enable,        // Main oscillator on
  output logic backup_osc_enable,      // Backup oscillator on
  output logic int_clk_en,             // Internal clock tick
  output logic core_reset,             // Core held in reset
  output logic io_force_pullup,        // Ports to input with pull-up
  output logic stack_clear,            // Clear return stack
  output logic [11:0] prog_addr,       // Program address bus
  input wire logic [7:0] prog_data,    // Program memory data
  output logic pc_load,                // Load PC pulse
  output logic [11:0] pc_value,        // PC value to load
  output logic nmi_mode_set            // Enter NMI mode and flags
);
  clock_guard_pkg::seq_state_t state_ff, nxt_state;
  logic [7:0] conv_ctrl_ff;
  logic [7:0] gap_cnt_ff;
  logic [1:0] miss_cnt_ff;
  logic main_run_ff;
  logic use_backup_ff;
  logic tick_ff;
  logic [7:0] vec_lo_ff;
  logic [11:0] pc_ff;
  logic pc_load_ff;
  logic [3:0] wdg_pin_ff;
  logic [2:0] cause_ff;
  logic [31:0] rdata_ff;
  logic wr_pend_ff;
  logic [7:0] wr_idx_ff;
  logic [11:0] addr_ff;

  delay_if #(.W(clock_guard_pkg::DELAY_W)) dly ();

  reset_delay_counter #(
    .DELAY(clock_guard_pkg::RESET_DELAY),
    .W(clock_guard_pkg::DELAY_W)
  ) u_delay (
    .hclk(hclk),
    .hresetn(hresetn),
    .dly(dly)
  );

  // Reset source merge; the pin is sampled in every mode
  wire pin_evt = !reset_pin_in;
  wire lvd_evt = lvd_enable_option && low_supply;
  wire any_evt = pin_evt || wdg_end_of_count || lvd_evt;
  wire in_reset = (state_ff != clock_guard_pkg::ST_RUN);

  // Oscillator control; off bit only counts with the safeguard present
  wire osc_off_bit = conv_ctrl_ff[clock_guard_pkg::OSC_OFF_BIT];
  wire main_req = !(safeguard_enable_option && osc_off_bit);

  // Source tick; backup only ever selected with the safeguard option
  wire src_tick = use_backup_ff ? backup_osc_edge : main_osc_edge;

  // Safeguard spacing for the present supply level
  wire [7:0] gap_min = (supply_level == 2'h0) ? clock_guard_pkg::GAP_L0 :
                       (supply_level == 2'h1) ? clock_guard_pkg::GAP_L1 :
                       (supply_level == 2'h2) ? clock_guard_pkg::GAP_L2 :
                       clock_guard_pkg::GAP_L3;
  // Backup ticks are slow and never filtered into nothing
  wire gap_ok = !safeguard_enable_option || (gap_cnt_ff >= gap_min);
  wire pass_tick = src_tick && gap_ok;

  // Missing-edge timeout, counted on backup edges since the last main edge
  wire miss_hit = backup_osc_edge && (miss_cnt_ff == clock_guard_pkg::MISS_PERIODS);
  wire [1:0] nxt_miss = main_osc_edge ? 2'h0 :
                        (backup_osc_edge && !miss_hit) ? miss_cnt_ff + 2'h1 : miss_cnt_ff;

  // Tick spacing counter saturates so a long idle always passes
  wire [7:0] nxt_gap = pass_tick ? 8'h00 :
                       (gap_cnt_ff == 8'hff) ? gap_cnt_ff : gap_cnt_ff + 8'h01;

  // Backup selection: set on timeout, dropped at the first main edge
  wire nxt_main_run = main_osc_edge ? 1'b1 : (miss_hit ? 1'b0 : main_run_ff);
  wire nxt_use_backup = safeguard_enable_option && !nxt_main_run;

  // Delay counter hookup; the tick comes from whichever source runs
  assign dly.tick = tick_ff;
  assign dly.clear = (state_ff == clock_guard_pkg::ST_HOLD);

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      clock_guard_pkg::ST_RUN: begin
        if (any_evt) begin
          nxt_state = clock_guard_pkg::ST_HOLD;
        end
      end
      clock_guard_pkg::ST_HOLD: begin
        if (!any_evt) begin
          nxt_state = clock_guard_pkg::ST_DELAY;
        end
      end
      clock_guard_pkg::ST_DELAY: begin
        if (any_evt) begin
          nxt_state = clock_guard_pkg::ST_HOLD;
        end else if (dly.done) begin
          nxt_state = clock_guard_pkg::ST_FETCH_LO;
        end
      end
      clock_guard_pkg::ST_FETCH_LO: begin
        if (any_evt) begin
          nxt_state = clock_guard_pkg::ST_HOLD;
        end else if (tick_ff) begin
          nxt_state = clock_guard_pkg::ST_FETCH_HI;
        end
      end
      clock_guard_pkg::ST_FETCH_HI: begin
        if (any_evt) begin
          nxt_state = clock_guard_pkg::ST_HOLD;
        end else if (tick_ff) begin
          nxt_state = clock_guard_pkg::ST_RUN;
        end
      end
      default: nxt_state = clock_guard_pkg::ST_HOLD;
    endcase
  end

  // Vector capture: first fetch tick reads FFEh, second FFFh
  wire fetch_lo_tick = (state_ff == clock_guard_pkg::ST_FETCH_LO) && tick_ff && !any_evt;
  wire fetch_hi_tick = (state_ff == clock_guard_pkg::ST_FETCH_HI) && tick_ff && !any_evt;
  wire [11:0] nxt_pc = fetch_hi_tick ? {vec_lo_ff[3:0], prog_data} : pc_ff;

  // Address bus parks on the vector until the fetch moves on
  wire [11:0] nxt_addr = (nxt_state == clock_guard_pkg::ST_FETCH_HI) ?
                         clock_guard_pkg::VEC_HI_ADDR :
                         (nxt_state == clock_guard_pkg::ST_RUN) ? addr_ff :
                         clock_guard_pkg::VEC_LO_ADDR;

  // Watchdog flag pulse on the pin, short by design
  wire [3:0] nxt_wdg_pin = wdg_end_of_count ? clock_guard_pkg::WDG_PIN_CYCLES :
                           (wdg_pin_ff != 4'h0) ? wdg_pin_ff - 4'h1 : 4'h0;

  // Cause bits latch on entry and stay until the next reset begins
  wire entering = (state_ff == clock_guard_pkg::ST_RUN) && any_evt;
  wire [2:0] nxt_cause = entering ? {lvd_evt, wdg_end_of_count, pin_evt} :
                         (in_reset ? (cause_ff | {lvd_evt, wdg_end_of_count, pin_evt}) :
                         cause_ff);

  // Clock path registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_cnt_ff <= 8'hff;
      miss_cnt_ff <= 2'h0;
      main_run_ff <= 1'b0;
      use_backup_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      gap_cnt_ff <= nxt_gap;
      miss_cnt_ff <= nxt_miss;
      main_run_ff <= nxt_main_run;
      use_backup_ff <= nxt_use_backup;
      tick_ff <= pass_tick;
    end
  end

  // Sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= clock_guard_pkg::ST_HOLD;
      vec_lo_ff <= 8'h00;
      pc_ff <= 12'h000;
      pc_load_ff <= 1'b0;
      wdg_pin_ff <= 4'h0;
      cause_ff <= 3'h0;
      addr_ff <= clock_guard_pkg::VEC_LO_ADDR;
    end else begin
      state_ff <= nxt_state;
      vec_lo_ff <= fetch_lo_tick ? prog_data : vec_lo_ff;
      pc_ff <= nxt_pc;
      pc_load_ff <= fetch_hi_tick;
      wdg_pin_ff <= nxt_wdg_pin;
      cause_ff <= nxt_cause;
      addr_ff <= nxt_addr;
    end
  end

  // AHB decode; word-aligned index from the byte address
  wire [7:0] bus_idx = haddr[clock_guard_pkg::ADDR_SHIFT +: 8];
  wire hi_zero = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  wire bus_take = hsel && hready && (htrans == clock_guard_pkg::HTRANS_NONSEQ);
  wire hit_ctrl = hi_zero && (bus_idx == clock_guard_pkg::IDX_CONV_CTRL);
  wire hit_stat = hi_zero && (bus_idx == clock_guard_pkg::IDX_STATUS);
  wire do_wr = wr_pend_ff && (wr_idx_ff == clock_guard_pkg::IDX_CONV_CTRL);

  // Status word: live state and latched causes
  wire [31:0] status_word = {26'h0, cause_ff, in_reset, main_run_ff, use_backup_ff};
  wire [31:0] nxt_rdata = (bus_take && !hwrite) ?
                          (hit_ctrl ? {24'h0, conv_ctrl_ff} :
                          (hit_stat ? status_word : 32'h0)) : rdata_ff;

  // Any reset restores the control register, which restarts the oscillator
  wire [7:0] nxt_ctrl = in_reset ? clock_guard_pkg::CONV_CTRL_RST :
                        (do_wr ? hwdata[7:0] : conv_ctrl_ff);

  // Bus registers; writes land in the data phase, reads answer there
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_ctrl_ff <= clock_guard_pkg::CONV_CTRL_RST;
      rdata_ff <= 32'h0;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
    end else begin
      conv_ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      wr_pend_ff <= bus_take && hwrite;
      wr_idx_ff <= (bus_take && hwrite && hit_ctrl) ? bus_idx : 8'h00;
    end
  end

  // Bus answers: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  // Oscillator enables; reset forces the main one on, even from stop
  assign main_osc_enable = main_req || in_reset;
  assign backup_osc_enable = safeguard_enable_option && !main_run_ff;
  // Core sees the same tick whatever the source, just fewer of them
  assign int_clk_en = tick_ff && !stop_mode;

  // Reset pin: held for low supply, brief pulse for the watchdog
  assign reset_pin_oe_n = !(lvd_evt || (wdg_pin_ff != 4'h0));
  assign reset_pin_out = 1'b0;

  // Core side of the sequence
  assign core_reset = in_reset;
  assign io_force_pullup = in_reset;
  assign stack_clear = in_reset;
  assign prog_addr = addr_ff;
  assign pc_value = pc_ff;
  assign pc_load = pc_load_ff;
  assign nmi_mode_set = pc_load_ff;
endmodule

// file: pkg/clock_guard_pkg.sv
/*
  Shared constants for the clock safeguard and reset sequencer: register
  indices, field positions, reset values, sequencing counts and states.
  Assumes a single 250 MHz bus clock; oscillator edges arrive as pulses.
*/
package clock_guard_pkg;
  // Bus clock and derived timing
  localparam int CLK_MHZ = 250;
  // Safeguard ceiling per supply level code, in MHz (plain defaults)
  localparam int SAFE_MHZ_L0 = 2;
  localparam int SAFE_MHZ_L1 = 4;
  localparam int SAFE_MHZ_L2 = 6;
  localparam int SAFE_MHZ_L3 = 8;
  // Least spacing of internal ticks, a least time so rounded up
  localparam logic [7:0] GAP_L0 = 8'((CLK_MHZ + SAFE_MHZ_L0 - 1) / SAFE_MHZ_L0);
  localparam logic [7:0] GAP_L1 = 8'((CLK_MHZ + SAFE_MHZ_L1 - 1) / SAFE_MHZ_L1);
  localparam logic [7:0] GAP_L2 = 8'((CLK_MHZ + SAFE_MHZ_L2 - 1) / SAFE_MHZ_L2);
  localparam logic [7:0] GAP_L3 = 8'((CLK_MHZ + SAFE_MHZ_L3 - 1) / SAFE_MHZ_L3);
  // Reset delay in internal clock cycles
  localparam int RESET_DELAY = 2048;
  localparam int DELAY_W = 12;
  // Backup periods without a main edge before failover
  localparam logic [1:0] MISS_PERIODS = 2'h1;
  // Watchdog flag pulse on the reset pin, in bus clocks
  localparam logic [3:0] WDG_PIN_CYCLES = 4'hf;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONV_CTRL = 8'hd1;
  localparam logic [7:0] IDX_STATUS = 8'hd2;
  localparam int ADDR_SHIFT = 2;
  localparam logic [7:0] CONV_CTRL_RST = 8'h40;
  localparam int OSC_OFF_BIT = 2;
  // Status field positions
  localparam int ST_BACKUP = 0;
  localparam int ST_MAIN_RUN = 1;
  localparam int ST_IN_RESET = 2;
  localparam int ST_CAUSE_PIN = 3;
  localparam int ST_CAUSE_WDG = 4;
  localparam int ST_CAUSE_LVD = 5;
  // Reset vector location
  localparam logic [11:0] VEC_LO_ADDR = 12'hffe;
  localparam logic [11:0] VEC_HI_ADDR = 12'hfff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {ST_RUN, ST_HOLD, ST_DELAY, ST_FETCH_LO, ST_FETCH_HI} seq_state_t;
endpackage

// file: pkg/delay_if.sv
/*
  Carrier between the sequencer and its delay counter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface delay_if #(parameter int W = 12);
  logic clear; // Restart the count
  logic tick;  // Internal clock enable
  logic done;  // Count reached
  modport seq (output clear, output tick, input done);
  modport cnt (input clear, input tick, output done);
endinterface

// file: hdl/reset_delay_counter.sv
/*
  Counts internal clock ticks after a reset event until the delay ends.
  Assumes clear and tick come from the sequencer on the bus clock.
*/
`timescale 1ns/1ps
module reset_delay_counter #(
  parameter int DELAY = clock_guard_pkg::RESET_DELAY,
  parameter int W = clock_guard_pkg::DELAY_W
) (
  input wire logic hclk,     // Bus clock
  input wire logic hresetn,  // Async reset, low
  delay_if.cnt dly           // Sequencer side
);
  logic [W:0] count_ff;
  logic [W:0] nxt_count;
  wire at_end = (count_ff == (W+1)'(DELAY));

  // Saturate at the end so done stays up until cleared
  assign nxt_count = dly.clear ? '0 :
                     (dly.tick && !at_end) ? count_ff + (W+1)'(1) : count_ff;
  assign dly.done = at_end;

  // Counter register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule

// file: sim/clock_guard_reset_sequencer_monitor.sv
/*
  Port checker for the clock guard reset sequencer.
  Assumes one hclk domain; bound from the bench top file.
*/
`timescale 1ns/1ps
module clock_guard_reset_sequencer_monitor (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, low
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic safeguard_enable_option, // Strap
  input wire logic lvd_enable_option, // Strap
  input wire logic [1:0] supply_level, // Level code
  input wire logic main_osc_edge, // Main edge
  input wire logic low_supply, // Low supply
  input wire logic wdg_end_of_count, // Watchdog
  input wire logic reset_pin_in, // Pin level
  input wire logic reset_pin_out, // Pin value
  input wire logic reset_pin_oe_n, // Pin enable
  input wire logic main_osc_enable, // Main on
  input wire logic backup_osc_enable, // Backup on
  input wire logic int_clk_en, // Tick
  input wire logic core_reset, // In reset
  input wire logic io_force_pullup, // Pulled-up ports
  input wire logic stack_clear, // Stack clear
  input wire logic [11:0] prog_addr, // Program address
  input wire logic pc_load, // PC load
  input wire logic nmi_mode_set // NMI mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles since last tick; armed only if that tick saw the option set
  logic [7:0] gap_ff;
  logic armed_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_ff <= 8'h00;
      armed_ff <= 1'b0;
    end else if (int_clk_en) begin
      gap_ff <= 8'h00;
      armed_ff <= safeguard_enable_option;
    end else if (gap_ff != 8'hff) begin
      gap_ff <= gap_ff + 8'h01;
    end
  end
  wire lvd_low = lvd_enable_option && low_supply;
  // Watchdog pulse, then 19 cycles with no new event
  sequence wdg_then_quiet;
    wdg_end_of_count ##1 (!wdg_end_of_count && !lvd_low)[*8]
      ##1 (!wdg_end_of_count && !lvd_low)[*8] ##1 (!wdg_end_of_count && !lvd_low)[*3];
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or not okay");
  lvd_pin_a: assert property (lvd_low |-> !reset_pin_oe_n && !reset_pin_out)
    else $error("pin not driven low during low supply");
  lvd_hold_a: assert property (lvd_low |=> core_reset)
    else $error("no reset during low supply");
  pin_hold_a: assert property (
    !reset_pin_in |=> core_reset && io_force_pullup && stack_clear)
    else $error("pin low did not hold reset");
  vec_addr_a: assert property (
    !reset_pin_in [*3] |-> prog_addr == clock_guard_pkg::VEC_LO_ADDR)
    else $error("vector address missing during reset");
  wdg_pull_a: assert property (
    wdg_end_of_count |=> core_reset && !reset_pin_oe_n ##1 (!reset_pin_oe_n)[*7])
    else $error("watchdog reset or pin pulse missing");
  wdg_brief_a: assert property (wdg_then_quiet |=> reset_pin_oe_n)
    else $error("watchdog pin pulse too long");
  load_nmi_a: assert property (pc_load |-> nmi_mode_set ##1 !pc_load)
    else $error("load pulse without nmi mode or too long");
  tick_gap_a: assert property (
    int_clk_en && armed_ff && safeguard_enable_option && supply_level == 2'h3
    |-> gap_ff >= clock_guard_pkg::GAP_L3 - 8'h01)
    else $error("ticks closer than ceiling allows");
  osc_keep_a: assert property (!safeguard_enable_option |-> main_osc_enable)
    else $error("main oscillator off without option");
  backup_off_a: assert property (
    safeguard_enable_option && main_osc_edge |-> ##[1:4] !backup_osc_enable)
    else $error("backup still on after main edge");
endmodule

// file: sim/reset_line_model.sv
/*
  Board reset line: pull-up plus one external device that can pull it.
  Assumes the sequencer only ever drives the line low.
*/
`timescale 1ns/1ps
module reset_line_model (
  input wire logic ext_low, // Board device pulls low
  input wire logic pin_out, // Sequencer drive value
  input wire logic pin_oe_n, // Sequencer enable, low drives
  output logic pin_level // Resolved level
);
  // Open drain with pull-up: any low driver wins, else high
  assign pin_level = ext_low ? 1'b0 : (!pin_oe_n ? pin_out : 1'b1);
endmodule

// file: sim/clock_guard_reset_sequencer_tb.sv
/*
  Self-checking bench for the clock guard reset sequencer.
  Assumes a 250 MHz hclk and a single AHB-Lite slave.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module clock_guard_reset_sequencer_tb;
  typedef struct packed {logic wr; logic [31:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  localparam logic [31:0] CTRL = 32'(clock_guard_pkg::IDX_CONV_CTRL) << clock_guard_pkg::ADDR_SHIFT;
  localparam logic [31:0] STAT = 32'(clock_guard_pkg::IDX_STATUS) << clock_guard_pkg::ADDR_SHIFT;
  localparam row_t ROWS [0:4] = '{'{1'b0, CTRL, 32'h0, 32'h40}, '{1'b1, CTRL, 32'hff, 32'hff},
    '{1'b1, CTRL, 32'h44, 32'h44}, '{1'b1, 32'h300, 32'h5a, 32'h0}, '{1'b1, CTRL, 32'h04, 32'h04}};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_low = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, supply_level = 2'h3;
  logic [2:0] hsize = 3'h2;
  logic safeguard_enable_option = 1'b0, lvd_enable_option = 1'b0, low_supply = 1'b0;
  logic main_osc_edge = 1'b0, backup_osc_edge = 1'b0, wdg_end_of_count = 1'b0, stop_mode = 1'b0;
  logic hready, hreadyout, hresp, reset_pin_in, reset_pin_out, reset_pin_oe_n, main_osc_enable;
  logic backup_osc_enable, int_clk_en, core_reset, io_force_pullup, stack_clear, pc_load;
  logic nmi_mode_set;
  logic [11:0] prog_addr, pc_value;
  logic [7:0] prog_data;
  logic [5:0] ph = 6'h0;
  int tick_n = 0, error_cnt = 0, n_compared = 0, n;
  clock_guard_reset_sequencer i_clock_guard_reset_sequencer (.*);
  reset_line_model i_reset_line_model (.ext_low(ext_low), .pin_out(reset_pin_out),
    .pin_oe_n(reset_pin_oe_n), .pin_level(reset_pin_in));
  assign hready = hreadyout;
  // Program memory: vector bytes, other places a filler
  assign prog_data = (prog_addr == 12'hffe) ? 8'h05 : (prog_addr == 12'hfff) ? 8'ha3 : 8'h3c;
  always #2 hclk = ~hclk;
  // Oscillators; backup also runs once main is switched off
  always @(posedge hclk) begin
    ph <= ph + 6'h01;
    main_osc_edge <= main_osc_enable && ph[0];
    backup_osc_edge <= (backup_osc_enable || main_osc_enable === 1'b0) && ph == 6'h3f;
  end
  // Ticks seen in reset since the pin last went high
  always @(posedge hclk) begin
    tick_n <= (!reset_pin_in || !hresetn) ? 0 : tick_n + int'(core_reset && int_clk_en);
  end
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= clock_guard_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_load;
    n = 0;
    while (pc_load !== 1'b1 && n < 20000) begin
      @(negedge hclk);
      n++;
    end
    `CHK("load seen", 1'b1, pc_load)
    `CHK("delay ticks", 1'b1, tick_n >= 2049 && tick_n <= 2052)
    `CHK("pc value", 12'h5a3, pc_value)
    `CHK("nmi on load", 1'b1, nmi_mode_set)
    repeat (2) @(negedge hclk);
    `CHK("run after load", 1'b0, core_reset)
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard, well beyond six reset sequences
  initial begin
    repeat (60000) @(posedge hclk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge hclk);
    @(negedge hclk);
    `CHK("vector addr", 12'hffe, prog_addr)
    `CHK("ports pulled", 1'b1, io_force_pullup)
    @(posedge hclk) hresetn <= 1'b1;
    wait_load;
    // Register rows, option clear so the off bit is ignored
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) bus(1'b1, ROWS[i].a, ROWS[i].d);
      bus(1'b0, ROWS[i].a, 32'h0);
      `CHK("reg read", ROWS[i].e, rd)
      `CHK("main kept", 1'b1, main_osc_enable)
    end
    // One-cycle pin pulse, write during reset refused
    @(posedge hclk) ext_low <= 1'b1;
    @(posedge hclk) ext_low <= 1'b0;
    bus(1'b1, CTRL, 32'hff);
    @(negedge hclk);
    `CHK("short pulse held", 1'b1, core_reset)
    `CHK("pin not driven", 1'b1, reset_pin_oe_n)
    wait_load;
    bus(1'b0, CTRL, 32'h0);
    `CHK("write in reset", 32'h40, rd)
    // Watchdog: brief pin flag, then normal restart
    @(posedge hclk) wdg_end_of_count <= 1'b1;
    @(posedge hclk) wdg_end_of_count <= 1'b0;
    n = 0;
    repeat (30) begin
      @(negedge hclk);
      n += int'(!reset_pin_oe_n);
    end
    `CHK("wdg pin cycles", 32'(clock_guard_pkg::WDG_PIN_CYCLES), n)
    wait_load;
    // Low supply ignored until the detector option is set
    @(posedge hclk) low_supply <= 1'b1;
    repeat (10) @(negedge hclk);
    `CHK("lvd off", 1'b0, core_reset)
    @(posedge hclk) lvd_enable_option <= 1'b1;
    repeat (50) @(negedge hclk);
    `CHK("lvd reset", 1'b1, core_reset)
    `CHK("lvd pin", 1'b0, reset_pin_oe_n)
    @(posedge hclk) low_supply <= 1'b0;
    wait_load;
    // Pin reset while stopped
    @(posedge hclk) stop_mode <= 1'b1;
    ext_low <= 1'b1;
    repeat (20) @(negedge hclk);
    `CHK("stop pulled", 1'b1, io_force_pullup)
    `CHK("stop osc", 1'b1, main_osc_enable)
    @(posedge hclk) ext_low <= 1'b0;
    stop_mode <= 1'b0;
    wait_load;
    bus(1'b0, STAT, 32'h0);
    `CHK("status pin cause", 32'h0a, rd)
    // Safeguard: switch main off, run on backup, switch back
    @(posedge hclk) safeguard_enable_option <= 1'b1;
    bus(1'b1, CTRL, 32'h44);
    @(negedge hclk);
    `CHK("main off", 1'b0, main_osc_enable)
    n = 0;
    while (!(backup_osc_enable === 1'b1 && int_clk_en === 1'b1) && n < 600) begin
      @(negedge hclk);
      n++;
    end
    `CHK("backup ticks", 1'b1, int_clk_en)
    bus(1'b0, STAT, 32'h0);
    `CHK("status backup", 32'h09, rd)
    bus(1'b1, CTRL, 32'h40);
    repeat (20) @(negedge hclk);
    `CHK("backup off", 1'b0, backup_osc_enable)
    // Lowest supply level: main ticks spread out to its ceiling
    @(posedge hclk) supply_level <= 2'h0;
    repeat (2) begin
      n = 0;
      do begin
        @(negedge hclk);
        n++;
      end while (int_clk_en !== 1'b1 && n < 400);
    end
    `CHK("low level gap", 1'b1, n >= int'(clock_guard_pkg::GAP_L0) && n < 400)
    // Mid-run reset: sequence restarts from the vector address
    @(posedge hclk) hresetn <= 1'b0;
    safeguard_enable_option <= 1'b0;
    repeat (2) @(negedge hclk);
    `CHK("reset vec addr", 12'hffe, prog_addr)
    `CHK("reset stack", 1'b1, stack_clear)
    @(posedge hclk) hresetn <= 1'b1;
    wait_load;
    tally_and_finish;
  end
endmodule
bind clock_guard_reset_sequencer clock_guard_reset_sequencer_monitor
  i_clock_guard_reset_sequencer_monitor (.*);
